// file: verilog/tkhd_core.sv
`timescale 1ns/100ps
`include "tkhd_map.svh"
module tkhd_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic unlocked,
  input wire tkhd_pkg::tkhd_bitcyc_t cyc,
  input wire logic abort_n,
  output logic serial_bit_line_o,
  output logic serial_bit_line_oe,
  output logic xfer_active,
  output logic osc_running,
  output logic afternoon_flag,
  output logic [7:0] hour_count_reg,
  output logic [7:0] weekday_control_reg
);
  ////////////////////////////////////////////////////////////////
  // Other registers of the set belong to another job; only hour and day live here
  logic [7:0] hour_r;
  logic [7:0] day_r;
  logic [7:0] shift_r;
  logic [19:0] div_r;
  logic dq_r;
  logic oe_r;
  logic act_q_r;
  logic osc_r;
  logic pm_r;
  logic [2:0] reg_idx;
  logic [2:0] bit_idx;
  logic last;
  logic active;
  logic [7:0] hour_inc;
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] tkhd_mask(input logic [2:0] idx);
    // Hour keeps mode, b5, b4 and four BCD units; day keeps its two controls and weekday
    case (idx)
      `TKHD_REG_HOUR: tkhd_mask = 8'hBF;
      `TKHD_REG_DAY: tkhd_mask = 8'h37;
      default: tkhd_mask = 8'hFF;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  wire abort_ignore = day_r[`TKHD_DAY_ABORT_BIT];
  wire abort_hit = !abort_ignore && !abort_n;
  wire start = unlocked && !active;
  wire step = cyc.rd || cyc.wr;
  wire in_hour = reg_idx == `TKHD_REG_HOUR;
  wire in_day = reg_idx == `TKHD_REG_DAY;
  wire mine = in_hour || in_day;
  wire [7:0] cur = in_hour ? hour_r : day_r;
  wire [7:0] shift_nxt = {cyc.wdata, shift_r[7:1]};
  // Commit only on the full byte, so a half-written register never lands
  wire commit = active && step && cyc.wr && mine && bit_idx == `TKHD_BIT_LAST && !abort_hit;
  wire [7:0] commit_val = shift_nxt & tkhd_mask(reg_idx);
  wire tick = !day_r[`TKHD_DAY_OSC_BIT] && div_r == `TKHD_TICK_DIV;
  // Mask is taken into a named wire first, since a function result cannot be indexed directly
  wire [7:0] cur_mask = tkhd_mask(reg_idx);
  wire rd_bit = cur[bit_idx] & cur_mask[bit_idx];
  ////////////////////////////////////////////////////////////////
  tkhd_ser u_ser (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(clk_en),
    .start(start),
    .abort(abort_hit),
    .step(step),
    .reg_idx(reg_idx),
    .bit_idx(bit_idx),
    .last(last),
    .active(active)
  );
  tkhd_bcd_inc u_inc (
    .hour_in(hour_r),
    .hour_out(hour_inc)
  );
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      day_r <= `TKHD_DAY_RESET;
      hour_r <= `TKHD_HOUR_RESET;
      shift_r <= 8'h00;
      div_r <= 20'h00000;
    end else if (clk_en) begin
      if (active && step && cyc.wr) shift_r <= shift_nxt;
      if (day_r[`TKHD_DAY_OSC_BIT]) div_r <= 20'h00000;
      else if (tick) div_r <= 20'h00000;
      else div_r <= div_r + 20'h00001;
      if (commit && in_day) day_r <= commit_val;
      if (commit && in_hour) hour_r <= commit_val;
      else if (tick && !(active && in_hour)) hour_r <= hour_inc;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dq_r <= 1'b0;
      oe_r <= 1'b0;
      act_q_r <= 1'b0;
      osc_r <= 1'b0;
      pm_r <= 1'b0;
    end else if (clk_en) begin
      dq_r <= active && cyc.rd && mine && rd_bit;
      oe_r <= active && cyc.rd && !abort_hit;
      act_q_r <= active && !abort_hit && !last;
      osc_r <= !day_r[`TKHD_DAY_OSC_BIT];
      pm_r <= hour_r[`TKHD_HOUR_MODE_BIT] && hour_r[`TKHD_HOUR_B5];
    end
  end
  assign serial_bit_line_o = dq_r;
  assign serial_bit_line_oe = oe_r;
  assign xfer_active = act_q_r;
  assign osc_running = osc_r;
  assign afternoon_flag = pm_r;
  assign hour_count_reg = hour_r;
  assign weekday_control_reg = day_r;
  ////////////////////////////////////////////////////////////////
  property p_reset_bits;
    @(posedge clk_sys) !rst_n |=> day_r[`TKHD_DAY_OSC_BIT] && day_r[`TKHD_DAY_ABORT_BIT];
  endproperty
  a_reset_bits: assert property (p_reset_bits) else $error("control bits not set after reset");
  property p_stop;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && day_r[`TKHD_DAY_OSC_BIT] && !commit |=> $stable(hour_r) || $past(commit);
  endproperty
  a_stop: assert property (p_stop) else $error("time advanced while stopped");
  property p_ignore;
    @(posedge clk_sys) disable iff (!rst_n) abort_ignore |-> !abort_hit;
  endproperty
  a_ignore: assert property (p_ignore) else $error("abort honoured while ignored");
  property p_abort;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en && abort_hit |=> !active ##0 $stable(day_r);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not end transfer");
  property p_zero;
    @(posedge clk_sys) disable iff (!rst_n) hour_r[6] == 1'b0 && day_r[7:6] == 2'h0 && day_r[3] == 1'b0;
  endproperty
  a_zero: assert property (p_zero) else $error("unused bit stored nonzero");
  property p_pm;
    @(posedge clk_sys) disable iff (!rst_n)
      clk_en |=> afternoon_flag == ($past(hour_r[7]) && $past(hour_r[5]));
  endproperty
  a_pm: assert property (p_pm) else $error("afternoon flag wrong");
  property p_24h;
    @(posedge clk_sys) disable iff (!rst_n) !hour_r[7] && hour_r[5] |-> hour_r[3:0] <= 4'h3;
  endproperty
  a_24h: assert property (p_24h) else $error("24-hour tens bit out of range");
  property p_end;
    @(posedge clk_sys) disable iff (!rst_n) clk_en && last && step && !abort_hit |=> !active;
  endproperty
  a_end: assert property (p_end) else $error("transfer did not end after 64 bits");
  property p_run;
    @(posedge clk_sys) disable iff (!rst_n) clk_en && !day_r[`TKHD_DAY_OSC_BIT] |=> osc_running;
  endproperty
  a_run: assert property (p_run) else $error("oscillator flag not running");
  c_commit_day: cover property (@(posedge clk_sys) commit && in_day);
  c_abort: cover property (@(posedge clk_sys) abort_hit && active);
  c_tick: cover property (@(posedge clk_sys) tick);
  c_last: cover property (@(posedge clk_sys) last && step);
endmodule

// file: verilog/tkhd_map.svh
`ifndef TKHD_MAP_SVH
`define TKHD_MAP_SVH
`define TKHD_NUM_REGS 4'h8
`define TKHD_REG_LAST 3'h7
`define TKHD_BIT_LAST 3'h7
`define TKHD_REG_HOUR 3'h4
`define TKHD_REG_DAY 3'h5
`define TKHD_HOUR_MODE_BIT 7
`define TKHD_HOUR_B5 5
`define TKHD_DAY_ABORT_BIT 4
`define TKHD_DAY_OSC_BIT 5
`define TKHD_DAY_RESET 8'h31
`define TKHD_TICK_DIV 20'h61A7F
`define TKHD_HOUR_RESET 8'h00
`endif

// file: verilog/tkhd_pkg.sv
package tkhd_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic wdata;
  } tkhd_bitcyc_t;
  typedef enum logic [1:0] {
    TKHD_IDLE,
    TKHD_XFER
  } tkhd_state_t;
endpackage

// file: verilog/tkhd_bcd_inc.sv
`timescale 1ns/100ps
`include "tkhd_map.svh"
module tkhd_bcd_inc (
  input wire logic [7:0] hour_in,
  output logic [7:0] hour_out
);
  ////////////////////////////////////////////////////////////////
  wire mode12 = hour_in[`TKHD_HOUR_MODE_BIT];
  wire [3:0] units = hour_in[3:0];
  wire [1:0] tens = hour_in[5:4];
  wire pm = hour_in[`TKHD_HOUR_B5];
  wire [3:0] u_inc = units + 4'h1;
  logic [7:0] nxt;
  always_comb begin
    nxt = hour_in;
    if (mode12) begin
      if (hour_in[4] && units == 4'h2) nxt = {hour_in[7:6], pm, 1'b0, 4'h1};
      else if (hour_in[4] && units == 4'h1) nxt = {hour_in[7:6], ~pm, 1'b1, 4'h2};
      else if (units == 4'h9) nxt = {hour_in[7:6], pm, 1'b1, 4'h0};
      else nxt = {hour_in[7:4], u_inc};
    end else begin
      if (tens == 2'h2 && units == 4'h3) nxt = {hour_in[7:6], 6'h00};
      else if (units == 4'h9) nxt = {hour_in[7:6], tens + 2'h1, 4'h0};
      else nxt = {hour_in[7:4], u_inc};
    end
  end
  assign hour_out = nxt;
endmodule

// file: verilog/tkhd_ser.sv
`timescale 1ns/100ps
`include "tkhd_map.svh"
module tkhd_ser (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic abort,
  input wire logic step,
  output logic [2:0] reg_idx,
  output logic [2:0] bit_idx,
  output logic last,
  output logic active
);
  ////////////////////////////////////////////////////////////////
  logic [2:0] reg_r;
  logic [2:0] bit_r;
  logic act_r;
  assign last = act_r && reg_r == `TKHD_REG_LAST && bit_r == `TKHD_BIT_LAST;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (ce && (abort || start))) begin
      reg_r <= 3'h0;
      bit_r <= 3'h0;
      act_r <= rst_n && start && !abort;
    end else if (ce && step && act_r) begin
      bit_r <= bit_r + 3'h1;
      if (bit_r == `TKHD_BIT_LAST) reg_r <= reg_r + 3'h1;
      if (last) act_r <= 1'b0;
    end
  end
  assign reg_idx = reg_r;
  assign bit_idx = bit_r;
  assign active = act_r;
endmodule

// file: dv/tkhd_host.sv
`timescale 1ns/100ps
module tkhd_host (
  input wire logic clk_sys,
  input wire logic line_o,
  input wire logic line_oe,
  output tkhd_pkg::tkhd_bitcyc_t cyc,
  output logic unlocked
);
  initial begin
    cyc = '0;
    unlocked = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Always a full 64-bit frame, so no register is half updated
  task automatic xfer(input logic wr, input logic [63:0] wb, input int gap, output logic [63:0] rb);
    @(posedge clk_sys);
    #1 unlocked = 1'b1;
    @(posedge clk_sys);
    #1 unlocked = 1'b0;
    for (int i = 0; i < 64; i++) begin
      cyc = '{rd: !wr, wr: wr, wdata: wb[i]};
      @(posedge clk_sys);
      #1 rb[i] = line_oe ? line_o : 1'bx;
      // Back to back cycles keep the strobe up, so it is never assigned twice in one step
      if (gap > 0 || i == 63) begin
        // Released data line shows the inverse, not a held value
        cyc = '{rd: 1'b0, wr: 1'b0, wdata: ~wb[i]};
        repeat (gap) @(posedge clk_sys);
        if (gap > 0) #1;
      end
    end
  endtask
endmodule

// file: dv/timekeeper_hour_day_control_tb.sv
`timescale 1ns/100ps
module timekeeper_hour_day_control_tb;
  logic clk_sys, rst_n, abort_n, lo, oe, act, osc, pm, unl, ce;
  logic [7:0] hr, dy;
  logic [63:0] rb;
  tkhd_pkg::tkhd_bitcyc_t cyc;
  int n_errors = 0;
  int n_tests = 0;
  int ncyc = 0;
  tkhd_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(ce), .unlocked(unl), .cyc(cyc), .abort_n(abort_n),
    .serial_bit_line_o(lo), .serial_bit_line_oe(oe), .xfer_active(act), .osc_running(osc), .afternoon_flag(pm),
    .hour_count_reg(hr), .weekday_control_reg(dy));
  tkhd_host host (.clk_sys(clk_sys), .line_o(lo), .line_oe(oe), .cyc(cyc), .unlocked(unl));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Whole run needs under 1000 cycles
  always @(posedge clk_sys) begin
    ncyc++;
    if (ncyc == 3000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [63:0] fr(logic [7:0] h, logic [7:0] d, logic [7:0] f);
    return {f, f, d, h, f, f, f, f};
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("day", 64'h31, dy);
    chk("osc", 64'h0, osc);
  endtask
  task automatic t_ignore();
    abort_n = 1'b0;
    host.xfer(1'b1, fr(8'hF2, 8'hFF, 8'hFF), 0, rb);
    chk("hour", 64'hB2, hr);
    chk("pm", 64'h1, pm);
    abort_n = 1'b1;
    host.xfer(1'b0, 64'h0, 2, rb);
    chk("frame", fr(8'hB2, 8'h37, 8'h00), rb);
    chk("osc", 64'h0, osc);
  endtask
  task automatic t_hour24();
    host.xfer(1'b1, fr(8'h23, 8'h01, 8'h00), 0, rb);
    chk("pm", 64'h0, pm);
    chk("osc", 64'h1, osc);
    host.xfer(1'b0, 64'h0, 0, rb);
    chk("frame", fr(8'h23, 8'h01, 8'h00), rb);
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    host.xfer(1'b1, fr(8'h05, 8'h21, 8'h00), 0, rb);
    ce = 1'b1;
    chk("hour", 64'h23, hr);
    chk("day", 64'h01, dy);
    chk("active", 64'h0, act);
  endtask
  task automatic t_abort();
    fork
      host.xfer(1'b1, fr(8'h11, 8'h30, 8'h00), 0, rb);
      begin
        repeat (36) @(posedge clk_sys);
        #1 chk("active", 64'h1, act);
        abort_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("active", 64'h0, act);
      end
    join
    abort_n = 1'b1;
    chk("hour", 64'h23, hr);
    chk("day", 64'h01, dy);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    abort_n = 1'b1;
    ce = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset();
    t_ignore();
    t_hour24();
    t_freeze();
    t_abort();
    test_done();
  end
endmodule
